// File: design/ipec_pkg.sv
package ipec_pkg;
  // Source counts and register file shape
  localparam int NSRC = 47;
  localparam int NREG = 7;
  localparam int NDISC_ENC = 4;
  localparam int FIXED_FIRST = 33;
  localparam int WAKE_PORT_LO = 6;
  localparam int WAKE_PORT_HI = 7;
  localparam int WAKE_TMR_LO = 33;
  localparam int WAKE_TMR_HI = 39;
  // Byte offsets on the bus
  localparam logic [7:0] OFF_IPR = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  localparam logic [7:0] OFF_EVT1 = 8'h20;
  localparam logic [7:0] OFF_EVT2 = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  // Reset values and control field positions
  localparam logic [15:0] IPR_RESET = 16'h0000;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int CTRL_ENC = 0;
  localparam int CTRL_RTC = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Writable bits per priority register; reserved nibbles read zero
  localparam logic [15:0] IPR_WMASK [NREG] = '{16'hFFFF, 16'hFFF0,
    16'hFFFF, 16'hFFFF, 16'hF0FF, 16'h0FFF, 16'hFFFF};
  // Fixed codes
  localparam logic [11:0] CODE_NMI = 12'h1C0;
  localparam logic [11:0] CODE_DBG = 12'h5E0;
  localparam logic [11:0] CODE_LVL15 = 12'h200;
  localparam logic [4:0] LVL_NMI = 5'h10;
  localparam logic [4:0] LVL_DBG = 5'h0F;
  // Per rank (0 = highest default order): priority field, source code
  localparam int SRC_FIELD [NSRC] = '{11, 10, 9, 8, 15, 14, 12, 13,
    16, 16, 16, 16, 18, 18, 18, 18, 19, 21, 23, 23, 23, 23, 24, 25, 26,
    27, 22, 22, 22, 22, 22, 22, 22, 0, 1, 2, 2, 3, 3, 3, 6, 6, 6, 6,
    4, 5, 5};
  localparam logic [11:0] SRC_CODE [NSRC] = '{12'h600, 12'h620,
    12'h640, 12'h660, 12'h680, 12'h6A0, 12'h700, 12'h720, 12'h800,
    12'h820, 12'h840, 12'h860, 12'h900, 12'h920, 12'h940, 12'h960,
    12'h980, 12'h9A0, 12'hB00, 12'hB20, 12'hB40, 12'hB60, 12'hA00,
    12'hA20, 12'hA40, 12'hA60, 12'h9C0, 12'h9C0, 12'h9C0, 12'h9C0,
    12'h9C0, 12'h9C0, 12'h9C0, 12'h400, 12'h420, 12'h440, 12'h460,
    12'h480, 12'h4A0, 12'h4C0, 12'h4E0, 12'h500, 12'h520, 12'h540,
    12'h560, 12'h580, 12'h5A0};
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_SRC = 2'b01,
    SEL_IRL = 2'b10,
    SEL_DBG = 2'b11
  } ipec_sel_t;
  // On-chip requests, first field highest in default order
  typedef struct packed {
    logic [0:3] dma;
    logic [0:3] fifoSerial;
    logic adc;
    logic display;
    logic [0:3] syncSerial;
    logic usbHost;
    logic [0:1] usbFunc;
    logic analogLink;
    logic [0:6] pcCard;
    logic [0:3] timer;
    logic [0:2] rtc;
    logic [0:3] serial;
    logic watchdog;
    logic [0:1] refresh;
  } ipec_periph_t;
  typedef struct packed {
    logic [11:0] primary;
    logic [11:0] secondary;
  } ipec_event_t;
endpackage : ipec_pkg

// File: design/ipec_core.sv
// Behaviour
// - Port inputs level-sensed, one field per eight
// - Acceptance never touches core mask bits
// - Port wake needs level above mask, RTC
// - Timer, RTC wake above mask with RTC
// - Peripherals programmable; debug fixed at fifteen
// - Source code latched into event registers
// - Reset clears every priority field
// - Equal priority ties follow default order
// - NMI level 16, debug fixed codes
// - Level-assigned primary code follows level
// - Discrete and port secondary codes, fields
// - Encoded pins give levels fifteen down
// - Shared field sources ranked internally
// - Timer to refresh use fixed codes
// - Shared vector, sources told by code
// - Field values rank sources zero to fifteen
// - Priority zero never raises a request
// - Fields accept zero to fifteen, zero masks
`timescale 1ns/1ps
module ipec_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] portRequestInputs,
  input wire logic [3:0] encodedLevelInputsN,
  input wire logic [5:0] discreteRequests,
  input wire logic nmiRequest,
  input wire logic debugRequest,
  input wire ipec_pkg::ipec_periph_t periphRequests,
  input wire logic [3:0] coreMaskBits,
  input wire logic standbyMode,
  input wire logic acceptPulse,
  output logic requestValid,
  output logic [4:0] requestLevel,
  output ipec_pkg::ipec_event_t eventCodes,
  output logic wakeUp
);
  logic [15:0] ipr [ipec_pkg::NREG];
  logic [1:0] ctrl;
  logic [25:0] syncA;
  logic [25:0] syncB;
  logic wrPend;
  logic [5:0] wrIdx;
  logic [0:ipec_pkg::NSRC-1] req;
  logic [3:0] srcLvl [ipec_pkg::NSRC];
  logic [ipec_pkg::NSRC-1:0] wakeAbove;
  logic [15:0] portSync;
  logic [3:0] irlSync;
  logic [5:0] discSync;
  logic [3:0] irlLvl;
  logic encMode;
  logic rtcOsc;
  logic addrPhase;
  logic [5:0] rdIdx;
  logic [31:0] rdMux;
  logic [4:0] bestLvl;
  ipec_pkg::ipec_sel_t bestSel;
  logic [5:0] bestRank;
  logic [11:0] lvlCode;
  logic [11:0] nextPrimary;
  logic [11:0] nextSecondary;
  logic winFixed;

  // Port, encoded and discrete pins pass two flops before anything reads them; NMI and debug do not
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      syncA <= 26'h0000000;
      syncB <= 26'h0000000;
    end
    else if (ce)
    begin
      syncA <= {portRequestInputs, encodedLevelInputsN, discreteRequests};
      syncB <= syncA;
    end
  assign portSync = syncB[25:10];
  assign irlSync = syncB[9:6];
  assign discSync = syncB[5:0];

  // Control bits
  assign encMode = ctrl[ipec_pkg::CTRL_ENC];
  assign rtcOsc = ctrl[ipec_pkg::CTRL_RTC];
  assign irlLvl = ~irlSync;

  // Request vector in default order
  assign req[0:5] = {<<{discSync}};
  assign req[6] = |portSync[7:0];
  assign req[7] = |portSync[15:8];
  assign req[8:ipec_pkg::NSRC-1] = periphRequests;

  // Per-source level from its shared field
  for (genvar r = 0; r < ipec_pkg::NSRC; r++)
  begin : g_src
    localparam int F = ipec_pkg::SRC_FIELD[r];
    localparam bit W = (r >= ipec_pkg::WAKE_PORT_LO &&
      r <= ipec_pkg::WAKE_PORT_HI) || (r >= ipec_pkg::WAKE_TMR_LO &&
      r <= ipec_pkg::WAKE_TMR_HI);
    localparam bit D = r < ipec_pkg::NDISC_ENC;
    wire logic [3:0] field = ipr[F / 4][15 - 4 * (F % 4) -: 4];
    // Discrete 0-3 share pins with the encoded inputs
    assign srcLvl[r] = (req[r] && !(D && encMode)) ? field : 4'h0;
    assign wakeAbove[r] = W && (srcLvl[r] > coreMaskBits);
  end

  // Ties: later candidates win only on >=, so scan low rank last
  always_comb
  begin
    bestLvl = 5'h00;
    bestSel = ipec_pkg::SEL_NONE;
    bestRank = 6'h00;
    for (int r = ipec_pkg::NSRC - 1; r >= 0; r--)
      if (srcLvl[r] != 4'h0 && {1'b0, srcLvl[r]} >= bestLvl)
      begin
        bestLvl = {1'b0, srcLvl[r]};
        bestSel = ipec_pkg::SEL_SRC;
        bestRank = 6'(r);
      end
    if (encMode && irlLvl != 4'h0 && {1'b0, irlLvl} >= bestLvl)
    begin
      bestLvl = {1'b0, irlLvl};
      bestSel = ipec_pkg::SEL_IRL;
    end
    if (debugRequest)
    begin
      bestLvl = ipec_pkg::LVL_DBG;
      bestSel = ipec_pkg::SEL_DBG;
    end
    if (nmiRequest)
      bestLvl = ipec_pkg::LVL_NMI;
  end

  // Event codes; one shared vector, sources told apart here
  assign lvlCode = ipec_pkg::CODE_LVL15 + {3'h0, ~bestLvl[3:0], 5'h00};
  assign winFixed = bestRank >= 6'(ipec_pkg::FIXED_FIRST);
  always_comb
  begin
    nextPrimary = 12'h000;
    nextSecondary = 12'h000;
    if (nmiRequest)
    begin
      nextPrimary = ipec_pkg::CODE_NMI;
      nextSecondary = ipec_pkg::CODE_NMI;
    end
    else
      case (bestSel)
        ipec_pkg::SEL_DBG:
        begin
          nextPrimary = ipec_pkg::CODE_DBG;
          nextSecondary = ipec_pkg::CODE_DBG;
        end
        ipec_pkg::SEL_IRL:
        begin
          nextPrimary = lvlCode;
          nextSecondary = lvlCode;
        end
        ipec_pkg::SEL_SRC:
        begin
          nextSecondary = ipec_pkg::SRC_CODE[bestRank];
          nextPrimary = winFixed ? ipec_pkg::SRC_CODE[bestRank]
            : lvlCode;
        end
        default:
        begin
          nextPrimary = 12'h000;
          nextSecondary = 12'h000;
        end
      endcase
  end

  // Core-facing state; the mask is only read, never written
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      requestValid <= 1'b0;
      requestLevel <= 5'h00;
      eventCodes <= '0;
      wakeUp <= 1'b0;
    end
    else if (ce)
    begin
      requestValid <= bestLvl > {1'b0, coreMaskBits};
      requestLevel <= bestLvl;
      if (acceptPulse)
        eventCodes <= {nextPrimary, nextSecondary};
      wakeUp <= standbyMode && rtcOsc && (|wakeAbove);
    end

  // Bus decode: zero wait; writes need word size, reads take any size
  assign addrPhase = hsel && htrans[1] && hready;
  assign rdIdx = haddr[7:2];
  always_comb
  begin
    rdMux = 32'h00000000;
    if (rdIdx < 6'(ipec_pkg::NREG))
      rdMux = {16'h0000, ipr[rdIdx[2:0]]};
    else if (rdIdx == ipec_pkg::OFF_CTRL[7:2])
      rdMux = {30'h00000000, ctrl};
    else if (rdIdx == ipec_pkg::OFF_EVT1[7:2])
      rdMux = {20'h00000, eventCodes.primary};
    else if (rdIdx == ipec_pkg::OFF_EVT2[7:2])
      rdMux = {20'h00000, eventCodes.secondary};
    else if (rdIdx == ipec_pkg::OFF_STAT[7:2])
      rdMux = {26'h0000000, requestValid, requestLevel};
  end

  // Address phase captured, data written next cycle
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      wrPend <= 1'b0;
      wrIdx <= 6'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      wrPend <= addrPhase && hwrite && hsize == ipec_pkg::HSIZE_WORD;
      wrIdx <= rdIdx;
      if (addrPhase && !hwrite)
        hrdata <= rdMux;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end

  // Register file; reset clears all priority fields
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < ipec_pkg::NREG; i++)
        ipr[i] <= ipec_pkg::IPR_RESET;
      ctrl <= ipec_pkg::CTRL_RESET;
    end
    else if (ce && wrPend)
    begin
      for (int i = 0; i < ipec_pkg::NREG; i++)
        if (wrIdx == 6'(i))
          ipr[i] <= hwdata[15:0] & ipec_pkg::IPR_WMASK[i];
      if (wrIdx == ipec_pkg::OFF_CTRL[7:2])
        ctrl <= hwdata[1:0];
    end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_zero_masked: assert property (requestValid |->
    requestLevel != 5'h00)
    else $error("request raised at level zero");
  a_above_mask: assert property ($past(ce) && requestValid |->
    $past(bestLvl) > {1'b0, $past(coreMaskBits)})
    else $error("request presented at or below mask");
  a_debug_fixed: assert property (debugRequest && !nmiRequest |->
    bestLvl == 5'h0F && bestSel == ipec_pkg::SEL_DBG)
    else $error("debug request not at level 15");
  a_nmi_code: assert property (ce && acceptPulse && nmiRequest |=>
    eventCodes.primary == 12'h1C0 && eventCodes.secondary == 12'h1C0)
    else $error("NMI code wrong");
  a_fixed_code: assert property (ce && acceptPulse && !nmiRequest &&
    bestSel == ipec_pkg::SEL_SRC && winFixed |=>
    eventCodes.primary == eventCodes.secondary)
    else $error("fixed source got a level code");
  a_level_code: assert property (ce && acceptPulse && !nmiRequest &&
    bestSel == ipec_pkg::SEL_SRC && !winFixed |=> eventCodes.primary ==
    12'h3E0 - {3'h0, $past(bestLvl[3:0]), 5'h00})
    else $error("level code wrong");
  a_irl_top: assert property (encMode && irlSync == 4'h0 &&
    !nmiRequest |-> bestLvl == 5'h0F)
    else $error("encoded 0000 not level 15");
  a_wake_gate: assert property ($past(ce) && wakeUp |->
    $past(rtcOsc) && $past(standbyMode))
    else $error("wake without oscillator or standby");
  a_evt_hold: assert property (!acceptPulse |=> $stable(eventCodes))
    else $error("event codes changed without acceptance");
  // Codes in the less common modes
  a_debug_code: assert property (ce && acceptPulse && !nmiRequest &&
    debugRequest |=> eventCodes.primary == 12'h5E0 &&
    eventCodes.secondary == 12'h5E0)
    else $error("debug code wrong");
  a_irl_code: assert property (ce && acceptPulse && !nmiRequest &&
    bestSel == ipec_pkg::SEL_IRL |=> eventCodes.primary ==
    eventCodes.secondary && eventCodes.primary ==
    12'h3E0 - {3'h0, $past(irlLvl), 5'h00})
    else $error("encoded pin code wrong");
  // Encoded mode borrows the pins of discrete 0-3
  a_enc_disc: assert property (encMode |-> srcLvl[0] == 4'h0 &&
    srcLvl[1] == 4'h0 && srcLvl[2] == 4'h0 && srcLvl[3] == 4'h0)
    else $error("discrete 0-3 active in encoded mode");

  c_nmi_accept: cover property (acceptPulse && nmiRequest);
  c_irl_accept: cover property (acceptPulse && bestSel == ipec_pkg::SEL_IRL);
  c_card_accept: cover property (acceptPulse && bestRank == 6'h1A);
  c_timer_accept: cover property (acceptPulse && winFixed &&
    bestSel == ipec_pkg::SEL_SRC);
  c_wake: cover property (wakeUp);
endmodule : ipec_core

// File: sim/ipec_core_model.sv
`timescale 1ns/1ps
// Core side: takes the presented request once armed, after a delay
module ipec_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic requestValid,
  input wire logic arm,
  input wire logic [3:0] delay,
  output logic acceptPulse
);
  logic [3:0] waitCnt;
  // One pulse per arming; bench drops arm on seeing it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acceptPulse <= 1'b0;
      waitCnt <= 4'h0;
    end
    else
    begin
      acceptPulse <= 1'b0;
      if (!arm || !requestValid)
        waitCnt <= 4'h0;
      else if (waitCnt == delay && !acceptPulse)
        acceptPulse <= 1'b1;
      else if (waitCnt != delay)
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : ipec_core_model

// File: sim/test_interrupt_priority_event_coder.sv
`timescale 1ns/1ps
module test_interrupt_priority_event_coder;
  logic clk, rst, hwrite, hreadyout, hresp, nmi, dbg, standby;
  logic requestValid, wakeUp, acceptPulse, arm;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] port;
  logic [3:0] encN, mask, delay;
  logic [5:0] disc;
  logic [4:0] requestLevel;
  ipec_pkg::ipec_periph_t periph;
  ipec_pkg::ipec_event_t eventCodes;
  int n_fail = 0;
  int check_count = 0;

  // Clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ipec_core u_dut (.clk(clk), .rst(rst), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .portRequestInputs(port),
    .encodedLevelInputsN(encN), .discreteRequests(disc),
    .nmiRequest(nmi), .debugRequest(dbg), .periphRequests(periph),
    .coreMaskBits(mask), .standbyMode(standby),
    .acceptPulse(acceptPulse), .requestValid(requestValid),
    .requestLevel(requestLevel), .eventCodes(eventCodes),
    .wakeUp(wakeUp));

  ipec_core_model u_core (.clk(clk), .rst(rst),
    .requestValid(requestValid), .arm(arm), .delay(delay),
    .acceptPulse(acceptPulse));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Single word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= ipec_pkg::HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Sync pins need 2 edges, then 1 more to the request outputs
  task automatic reqChk(input logic [4:0] lvl, input logic vld);
    repeat (4) @(posedge clk);
    chk({31'h0, requestValid}, {31'h0, vld});
    chk({27'h0, requestLevel}, {27'h0, lvl});
  endtask : reqChk

  task automatic acceptChk(input logic [11:0] p, input logic [11:0] s);
    int n;
    n = 0;
    arm <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (acceptPulse !== 1'b1 && n < 20);
    chk({31'h0, acceptPulse}, 32'h1);
    arm <= 1'b0;
    @(posedge clk);
    chk({8'h00, eventCodes}, {8'h00, p, s});
  endtask : acceptChk

  task automatic testReset;
    for (int i = 0; i < ipec_pkg::NREG; i++)
    begin
      ahb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    ahb(1'b0, ipec_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    $display("testReset done");
  endtask : testReset

  task automatic testNmiDbg;
    nmi <= 1'b1;
    dbg <= 1'b1;
    reqChk(5'h10, 1'b1);
    acceptChk(12'h1C0, 12'h1C0);
    nmi <= 1'b0;
    reqChk(5'h0F, 1'b1);
    acceptChk(12'h5E0, 12'h5E0);
    dbg <= 1'b0;
    $display("testNmiDbg done");
  endtask : testNmiDbg

  // Every encoded value, answered after a delay rising from 0 to 14 cycles
  task automatic testEncoded;
    for (int k = 0; k < 15; k++)
    begin
      encN <= 4'(k);
      delay <= 4'(k);
      reqChk(5'(15 - k), 1'b1);
      acceptChk(12'h200 + 12'(k * 32), 12'h200 + 12'(k * 32));
    end
    encN <= 4'hF;
    delay <= 4'h0;
    reqChk(5'h00, 1'b0);
    $display("testEncoded done");
  endtask : testEncoded

  task automatic testPort;
    ahb(1'b1, ipec_pkg::OFF_CTRL, 32'h0);
    port <= 16'h1004;
    reqChk(5'h00, 1'b0);
    ahb(1'b1, 8'h0C, 32'hAA00);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'hAA00);
    mask <= 4'hA;
    reqChk(5'h0A, 1'b0);
    mask <= 4'h9;
    reqChk(5'h0A, 1'b1);
    acceptChk(12'h2A0, 12'h700);
    port <= 16'h1000;
    reqChk(5'h0A, 1'b1);
    acceptChk(12'h2A0, 12'h720);
    standby <= 1'b1;
    ahb(1'b1, ipec_pkg::OFF_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    chk({31'h0, wakeUp}, 32'h1);
    mask <= 4'hA;
    repeat (4) @(posedge clk);
    chk({31'h0, wakeUp}, 32'h0);
    port <= 16'h0000;
    mask <= 4'h0;
    standby <= 1'b0;
    ahb(1'b1, 8'h08, 32'h5000);
    disc <= 6'h08;
    reqChk(5'h05, 1'b1);
    acceptChk(12'h340, 12'h660);
    disc <= 6'h00;
    $display("testPort done");
  endtask : testPort

  task automatic testTimer;
    ahb(1'b1, 8'h00, 32'hF000);
    periph.timer[0] <= 1'b1;
    dbg <= 1'b1;
    reqChk(5'h0F, 1'b1);
    acceptChk(12'h5E0, 12'h5E0);
    dbg <= 1'b0;
    acceptChk(12'h400, 12'h400);
    standby <= 1'b1;
    mask <= 4'hE;
    repeat (4) @(posedge clk);
    chk({31'h0, wakeUp}, 32'h1);
    ahb(1'b1, ipec_pkg::OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk({31'h0, wakeUp}, 32'h0);
    $display("testTimer done");
  endtask : testTimer

  task automatic results;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end

  // Inputs start quiet; reset held for 8 cycles
  initial
  begin
    rst = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    port = 16'h0000;
    encN = 4'hF;
    disc = 6'h00;
    nmi = 1'b0;
    dbg = 1'b0;
    periph = '0;
    mask = 4'h0;
    standby = 1'b0;
    arm = 1'b0;
    delay = 4'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    testReset();
    testNmiDbg();
    testEncoded();
    testPort();
    testTimer();
    results();
  end
endmodule : test_interrupt_priority_event_coder
